// file: sasf_map.svh
// register widths, flag thresholds, reset values and encodings for the serial/audio status block
`ifndef SASF_MAP_SVH
`define SASF_MAP_SVH
`define SASF_WORD_W        16
`define SASF_LEVEL_W       6
`define SASF_FIFO_BYTES    6'h20
`define SASF_THR_BYTE      6'h01
`define SASF_THR_HALF      6'h02
`define SASF_STD_DELAYED   2'h0
`define SASF_STD_MSB       2'h1
`define SASF_STD_LSB       2'h2
`define SASF_STD_PCM       2'h3
`define SASF_LEN_16        2'h0
`define SASF_LEN_24        2'h1
`define SASF_LEN_32        2'h2
`define SASF_PCM_LONG_BITS 6'h0d
`define SASF_PCM_SHORT_BITS 6'h01
`define SASF_WORD_RST      16'h0000
`endif

// file: sasf_pkg.sv
// shared types of the serial/audio status block
package sasf_pkg;
  typedef enum logic [1:0]
  {
    SASF_STD_DELAYED = 2'b00,
    SASF_STD_MSB     = 2'b01,
    SASF_STD_LSB     = 2'b10,
    SASF_STD_PCM     = 2'b11
  } sasf_std_t;
  typedef enum logic [1:0]
  {
    SASF_LEN_16 = 2'b00,
    SASF_LEN_24 = 2'b01,
    SASF_LEN_32 = 2'b10,
    SASF_LEN_RSV = 2'b11
  } sasf_len_t;
endpackage

// file: sasf_status.sv
// status, error flags and audio word framing of the serial/audio port
`timescale 1ns/1ps
`include "sasf_map.svh"
module sasf_status
#(
  parameter int FIFO_BYTES = 32
)
(
  // clocks and reset
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  input  wire logic                 clk_en_in,
  input  wire logic                 link_clk_in,
  // data port and register accesses
  input  wire logic                 data_wr_in,
  input  wire logic [15:0]          data_wdata_in,
  input  wire logic                 data_rd_in,
  output logic      [15:0]          data_rdata_out,
  input  wire logic                 status_rd_in,
  input  wire logic                 status_wr_in,
  input  wire logic                 status_crc_bit_in,
  input  wire logic                 ctrl1_wr_in,
  // control bits
  input  wire logic                 port_enable_in,
  input  wire logic                 master_select_in,
  input  wire logic                 crc_enable_in,
  input  wire logic                 sw_select_mgmt_in,
  input  wire logic                 internal_select_level_in,
  input  wire logic                 tx_space_irq_en_in,
  input  wire logic                 rx_avail_irq_en_in,
  input  wire logic                 error_irq_en_in,
  input  wire logic                 rx_threshold_sel_in,
  input  wire logic                 sync_frame_format_in,
  // audio configuration
  input  wire logic                 audio_mode_select_in,
  input  wire logic                 audio_transmit_in,
  input  wire sasf_pkg::sasf_std_t  audio_standard_select_in,
  input  wire logic                 pcm_frame_sync_select_in,
  input  wire sasf_pkg::sasf_len_t  sample_length_in,
  input  wire logic                 slot_length_in,
  input  wire logic                 master_clock_out_en_in,
  // shift engine status
  input  wire logic [5:0]           tx_fifo_level_in,
  input  wire logic [5:0]           rx_fifo_level_in,
  input  wire logic                 rx_push_in,
  input  wire logic                 engine_active_in,
  input  wire logic                 item_gap_in,
  input  wire logic                 frame_active_in,
  input  wire logic                 crc_check_in,
  input  wire logic [15:0]          rx_check_value_in,
  input  wire logic [15:0]          crc_calc_value_in,
  // pins
  input  wire logic                 slave_select_pin_in,
  input  wire logic                 sck_in,
  output logic                      sck_out,
  output logic                      sck_oe_out,
  output logic                      audio_master_clock_out,
  output logic                      audio_master_clock_oe_out,
  input  wire logic                 ws_in,
  output logic                      ws_out,
  output logic                      ws_oe_out,
  input  wire logic                 sd_in,
  output logic                      sd_out,
  output logic                      sd_oe_out,
  // flags and controls out
  output logic                      port_enable_out,
  output logic                      master_select_out,
  output logic                      tx_space_flag_out,
  output logic                      rx_avail_flag_out,
  output logic                      busy_flag_out,
  output logic                      mode_fault_flag_out,
  output logic                      overrun_flag_out,
  output logic                      crc_error_flag_out,
  output logic                      frame_error_flag_out,
  output logic                      frame_wait_out,
  output logic                      rx_store_en_out,
  output logic                      irq_out
);
  import sasf_pkg::*;

  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic [5:0] sample_bits(input sasf_len_t len);
    case (len)
      SASF_LEN_24: sample_bits = 6'h18;
      SASF_LEN_32: sample_bits = 6'h20;
      default:     sample_bits = 6'h10;
    endcase
  endfunction

  // ********************************************************************
  // bus clock domain
  // ********************************************************************
  logic       ss_meta;
  logic       ss_sync;
  logic       ss_prev;
  logic [2:0] ack_sync;
  logic [2:0] rxt_sync;
  logic       tx_req;
  logic [15:0] tx_word;
  logic       mf_armed;
  logic       ovr_armed;
  logic       link_ack;
  logic       rx_tgl;
  logic [15:0] rx_word;
  logic       next_mode_fault;
  logic       ss_pulse;
  logic       audio_rx_evt;
  logic       spi_ovr_evt;
  logic       crc_evt;
  logic       frame_evt;

  // the select pin is foreign to this clock; two flops before use
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      ss_meta <= 1'b1;
      ss_sync <= 1'b1;
      ss_prev <= 1'b1;
    end
    else if (clk_en_in)
    begin
      ss_meta <= slave_select_pin_in;
      ss_sync <= ss_meta;
      ss_prev <= ss_sync;
    end

  // link handshake levels and the receive toggle cross in two flops
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      ack_sync <= 3'h0;
      rxt_sync <= 3'h0;
    end
    else if (clk_en_in)
    begin
      ack_sync <= {ack_sync[1:0], link_ack};
      rxt_sync <= {rxt_sync[1:0], rx_tgl};
    end

  // event terms
  always_comb
  begin
    next_mode_fault = port_enable_out & master_select_out &
                      (sw_select_mgmt_in ? ~internal_select_level_in
                                         : ~ss_sync);
    ss_pulse     = ss_sync & ~ss_prev;
    audio_rx_evt = audio_mode_select_in & (rxt_sync[2] ^ rxt_sync[1]);
    spi_ovr_evt  = ~audio_mode_select_in & rx_push_in &
                   (rx_fifo_level_in >= 6'(FIFO_BYTES));
    crc_evt      = crc_enable_in & crc_check_in &
                   (rx_check_value_in != crc_calc_value_in);
    frame_evt    = port_enable_out & ~master_select_out &
                   sync_frame_format_in & frame_active_in &
                   ss_pulse;
  end

  // port enable and master select; a fault wins over any write
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      port_enable_out   <= 1'b0;
      master_select_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (next_mode_fault)
      begin
        port_enable_out   <= 1'b0;
        master_select_out <= 1'b0;
      end
      else if (ctrl1_wr_in)
      begin
        // while faulted only clearing is honoured
        port_enable_out   <= port_enable_in &
                             (~mode_fault_flag_out | port_enable_out);
        master_select_out <= master_select_in &
                             (~mode_fault_flag_out | master_select_out);
      end
    end

  // mode fault flag: status access arms, control write then clears
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      mode_fault_flag_out <= 1'b0;
      mf_armed            <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (next_mode_fault)
      begin
        mode_fault_flag_out <= 1'b1;
        mf_armed            <= 1'b0;
      end
      else if (mode_fault_flag_out)
      begin
        if (ctrl1_wr_in && mf_armed)
          mode_fault_flag_out <= 1'b0;
        if (status_rd_in || status_wr_in)
          mf_armed <= 1'b1;
        else if (ctrl1_wr_in)
          mf_armed <= 1'b0;
      end
      else
        mf_armed <= 1'b0;
    end

  // overrun: a data read arms, the following status read clears
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      overrun_flag_out <= 1'b0;
      ovr_armed        <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (spi_ovr_evt || (audio_rx_evt && rx_avail_flag_out))
      begin
        overrun_flag_out <= 1'b1;
        ovr_armed        <= 1'b0;
      end
      else if (data_rd_in)
        ovr_armed <= overrun_flag_out;
      else if (status_rd_in && ovr_armed)
      begin
        overrun_flag_out <= 1'b0;
        ovr_armed        <= 1'b0;
      end
    end

  // crc error and frame error flags; setting beats clearing
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      crc_error_flag_out   <= 1'b0;
      frame_error_flag_out <= 1'b0;
      frame_wait_out       <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (crc_evt)
        crc_error_flag_out <= 1'b1;
      else if (status_wr_in && !status_crc_bit_in)
        crc_error_flag_out <= 1'b0;
      if (frame_evt)
        frame_error_flag_out <= 1'b1;
      else if (status_rd_in)
        frame_error_flag_out <= 1'b0;
      // the offending pulse is ignored; resume on the next clean one
      if (frame_evt)
        frame_wait_out <= 1'b1;
      else if (ss_pulse)
        frame_wait_out <= 1'b0;
    end

  // transmit word hand-off; writes while no space are dropped
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      tx_req  <= 1'b0;
      tx_word <= `SASF_WORD_RST;
    end
    else if (clk_en_in)
    begin
      if (audio_mode_select_in && data_wr_in && tx_space_flag_out)
      begin
        tx_req  <= 1'b1;
        tx_word <= data_wdata_in;
      end
      else if (ack_sync[1])
        tx_req <= 1'b0;
    end

  // space and available flags, registered so the outputs are flops
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      tx_space_flag_out <= 1'b0;
      rx_avail_flag_out <= 1'b0;
      data_rdata_out    <= `SASF_WORD_RST;
    end
    else if (clk_en_in)
    begin
      if (audio_mode_select_in)
      begin
        tx_space_flag_out <= ~tx_req & ~ack_sync[1] &
                             ~(data_wr_in & tx_space_flag_out);
        // a new word is held back after overrun; old data stays
        if (audio_rx_evt && !rx_avail_flag_out && !overrun_flag_out)
        begin
          rx_avail_flag_out <= 1'b1;
          data_rdata_out    <= rx_word;
        end
        else if (data_rd_in)
          rx_avail_flag_out <= 1'b0;
      end
      else
      begin
        tx_space_flag_out <= (tx_fifo_level_in <=
                              6'(FIFO_BYTES / 2));
        rx_avail_flag_out <= rx_fifo_level_in >= (rx_threshold_sel_in ?
                             `SASF_THR_HALF : `SASF_THR_BYTE);
      end
    end

  // busy and store enable
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      busy_flag_out   <= 1'b0;
      rx_store_en_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      // master ends or faults drop it; a slave shows each item gap
      busy_flag_out <= port_enable_out & ~next_mode_fault &
                       (audio_mode_select_in ? (tx_req | ack_sync[1])
                        : engine_active_in &
                          ~(~master_select_out & item_gap_in));
      rx_store_en_out <= ~(overrun_flag_out | spi_ovr_evt);
    end

  // single request line
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
      irq_out <= 1'b0;
    else if (clk_en_in)
      irq_out <= (tx_space_flag_out & tx_space_irq_en_in) |
                 (rx_avail_flag_out & rx_avail_irq_en_in) |
                 (error_irq_en_in &
                  (mode_fault_flag_out | overrun_flag_out |
                   crc_error_flag_out | frame_error_flag_out));

  // audio serial clock and master clock, made by halving the bus clock
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      sck_out                   <= 1'b0;
      sck_oe_out                <= 1'b0;
      audio_master_clock_out    <= 1'b0;
      audio_master_clock_oe_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      sck_oe_out <= audio_mode_select_in & master_select_out &
                    port_enable_out;
      sck_out    <= sck_oe_out & ~sck_out;
      audio_master_clock_oe_out <= sck_oe_out & master_clock_out_en_in;
      audio_master_clock_out    <= audio_master_clock_oe_out &
                                   ~audio_master_clock_out;
    end

  // ********************************************************************
  // link clock domain
  // ********************************************************************
  // configuration pins are only changed while the port is disabled
  logic [1:0] en_sync;
  logic [1:0] req_sync;
  logic       lk_master;
  logic       ms_meta;
  logic [5:0] bit_pos;
  logic       chan;
  logic       ws_prev;
  logic [15:0] stage_word;
  logic       stage_full;
  logic [15:0] tx_shift;
  logic       tx_bit;
  logic       ws_next;
  logic [15:0] rx_shift;
  logic [5:0] slot_mask;
  logic [5:0] len_bits;
  logic [5:0] delay;
  logic [5:0] pos_cur;
  logic [5:0] pos_nxt;
  logic [5:0] q_cur;
  logic [5:0] q_nxt;
  logic       ws_edge;

  // position arithmetic; slots are powers of two so masking wraps
  always_comb
  begin
    slot_mask = slot_length_in ? 6'h1f : 6'h0f;
    len_bits  = sample_bits(sample_length_in);
    case (audio_standard_select_in)
      SASF_STD_DELAYED: delay = 6'h01;
      SASF_STD_LSB:     delay = (slot_mask + 6'h01) - len_bits;
      default:          delay = 6'h00;
    endcase
    ws_edge = (audio_standard_select_in == SASF_STD_PCM) ?
              (ws_in & ~ws_prev) : (ws_in ^ ws_prev);
    pos_cur = (!lk_master && ws_edge) ? 6'h00 : bit_pos;
    pos_nxt = (pos_cur + 6'h01) & slot_mask;
    q_cur   = (pos_cur - delay) & slot_mask;
    q_nxt   = (pos_nxt - delay) & slot_mask;
  end

  // enable, role and transmit request cross in two flops
  always_ff @(posedge link_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      en_sync   <= 2'h0;
      req_sync  <= 2'h0;
      ms_meta   <= 1'b0;
      lk_master <= 1'b0;
    end
    else
    begin
      en_sync   <= {en_sync[0], audio_mode_select_in & port_enable_out};
      req_sync  <= {req_sync[0], tx_req};
      ms_meta   <= master_select_out;
      lk_master <= ms_meta;
    end

  // slot position, channel and word select for the next falling edge
  always_ff @(posedge link_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      bit_pos <= 6'h00;
      chan    <= 1'b0;
      ws_prev <= 1'b0;
      ws_next <= 1'b0;
    end
    else if (en_sync[1])
    begin
      bit_pos <= pos_nxt;
      ws_prev <= ws_in;
      if (audio_standard_select_in == SASF_STD_PCM)
      begin
        // single channel; frame sync is one or thirteen bits
        chan    <= 1'b0;
        ws_next <= pos_nxt < (pcm_frame_sync_select_in ?
                   `SASF_PCM_LONG_BITS : `SASF_PCM_SHORT_BITS);
      end
      else if (lk_master)
      begin
        // left first, then right; select leads data in delayed mode
        if (pos_nxt == 6'h00)
          chan <= ~chan;
        ws_next <= (pos_nxt == 6'h00) ? ~chan : chan;
      end
      else
        chan <= ws_in;
    end

  // handshake: copy the word once, release after request drops
  always_ff @(posedge link_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      link_ack   <= 1'b0;
      stage_full <= 1'b0;
      stage_word <= `SASF_WORD_RST;
      tx_shift   <= `SASF_WORD_RST;
      tx_bit     <= 1'b0;
    end
    else
    begin
      if (!req_sync[1])
        link_ack <= 1'b0;
      else if (!link_ack && !stage_full)
      begin
        link_ack   <= 1'b1;
        stage_word <= tx_word;
      end
      if (en_sync[1] && audio_transmit_in && (q_nxt < len_bits))
      begin
        if (q_nxt[3:0] == 4'h0)
        begin
          // each half of a long sample is its own word, upper first
          tx_bit     <= stage_word[15] & stage_full;
          tx_shift   <= stage_full ? {stage_word[14:0], 1'b0}
                                   : `SASF_WORD_RST;
          stage_full <= 1'b0;
        end
        else
        begin
          tx_bit   <= tx_shift[15];
          tx_shift <= {tx_shift[14:0], 1'b0};
        end
      end
      else
        tx_bit <= 1'b0;
      if (!req_sync[1] && link_ack)
        stage_full <= 1'b1;
    end

  // receive on the rising edge; partial words are left-justified
  always_ff @(posedge link_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      rx_shift <= `SASF_WORD_RST;
      rx_word  <= `SASF_WORD_RST;
      rx_tgl   <= 1'b0;
    end
    else if (en_sync[1] && !audio_transmit_in && (q_cur < len_bits))
    begin
      rx_shift <= {rx_shift[14:0], sd_in};
      if (q_cur == len_bits - 6'h01 && q_cur[3:0] != 4'hf)
      begin
        rx_word <= {rx_shift[6:0], sd_in, 8'h00};
        rx_tgl  <= ~rx_tgl;
      end
      else if (q_cur[3:0] == 4'hf)
      begin
        rx_word <= {rx_shift[14:0], sd_in};
        rx_tgl  <= ~rx_tgl;
      end
    end

  // data and word select change on the falling edge
  always_ff @(negedge link_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      sd_out    <= 1'b0;
      sd_oe_out <= 1'b0;
      ws_out    <= 1'b0;
      ws_oe_out <= 1'b0;
    end
    else
    begin
      sd_out    <= tx_bit;
      sd_oe_out <= en_sync[1] & audio_transmit_in;
      ws_out    <= ws_next;
      ws_oe_out <= en_sync[1] & lk_master;
    end

endmodule // sasf_status

// file: sasf_status_assertions.sv
// checker of the serial/audio status block
`timescale 1ns/1ps
module sasf_status_assertions
#(
  parameter int FIFO_BYTES = 32
)
(
  // inputs watched
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  input wire logic       audio_mode_select_in,
  input wire logic [5:0] tx_fifo_level_in,
  input wire logic [5:0] rx_fifo_level_in,
  input wire logic       rx_threshold_sel_in,
  input wire logic       tx_space_irq_en_in,
  input wire logic       rx_avail_irq_en_in,
  input wire logic       error_irq_en_in,
  input wire logic       status_wr_in,
  input wire logic       status_rd_in,
  // outputs watched
  input wire logic       tx_space_flag_out,
  input wire logic       rx_avail_flag_out,
  input wire logic       mode_fault_flag_out,
  input wire logic       overrun_flag_out,
  input wire logic       crc_error_flag_out,
  input wire logic       frame_error_flag_out,
  input wire logic       port_enable_out,
  input wire logic       master_select_out,
  input wire logic       irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  localparam int HALF = FIFO_BYTES / 2;
  logic ev;
  // gated event sum that the single request line must follow
  assign ev = (tx_space_flag_out && tx_space_irq_en_in)
    || (rx_avail_flag_out && rx_avail_irq_en_in) || (error_irq_en_in
    && (mode_fault_flag_out || overrun_flag_out || crc_error_flag_out
    || frame_error_flag_out));
  property p_tx_full;
    !audio_mode_select_in && tx_fifo_level_in > 6'(HALF)
      |=> !tx_space_flag_out;
  endproperty
  a_tx_full: assert property (p_tx_full) else $error("space flag high");
  property p_rx_low;
    !audio_mode_select_in && rx_threshold_sel_in
      && rx_fifo_level_in < 6'h02 |=> !rx_avail_flag_out;
  endproperty
  a_rx_low: assert property (p_rx_low) else $error("avail flag high");
  property p_irq_on;
    ev |=> irq_out;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  property p_irq_off;
    !ev |=> !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq stray");
  property p_fault_off;
    mode_fault_flag_out |-> !port_enable_out && !master_select_out;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault on");
  property p_fault_src;
    $rose(mode_fault_flag_out) |-> $past(master_select_out);
  endproperty
  a_fault_src: assert property (p_fault_src) else $error("fault src");
  property p_crc_hold;
    crc_error_flag_out && !status_wr_in |=> crc_error_flag_out;
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc lost");
  property p_fre_clr;
    $fell(frame_error_flag_out) |-> $past(status_rd_in);
  endproperty
  a_fre_clr: assert property (p_fre_clr) else $error("frame clr");
  property p_ovr_clr;
    $fell(overrun_flag_out) |-> $past(status_rd_in);
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("ovr clr");
  c_fault: cover property ($rose(mode_fault_flag_out));
  c_frame: cover property ($rose(frame_error_flag_out));
  c_crc: cover property ($rose(crc_error_flag_out));
endmodule // sasf_status_assertions
bind sasf_status sasf_status_assertions #(.FIFO_BYTES(FIFO_BYTES))
  sasf_status_assertions_i (.*);

// file: sasf_link_model.sv
// far-side serial master model: link clock, select pin, data line
`timescale 1ns/1ps
module sasf_link_model
(
  // requests from the bench
  input  wire logic run_in,
  input  wire logic pulse_in,
  // pins seen by the port
  output logic      link_clk_out,
  output logic      select_n_out,
  output logic      sd_out
);
  // 15 ns clock, off phase with the bus clock, still between frames
  initial
  begin
    link_clk_out = 1'h0;
    #1.3;
    forever #7.5 link_clk_out = run_in ? !link_clk_out : 1'h0;
  end
  // select pulse on request; data toggles so stale bits show
  initial
  begin
    {select_n_out, sd_out} = 2'h2;
    forever @(negedge link_clk_out)
    begin
      select_n_out <= !pulse_in;
      sd_out       <= !sd_out;
    end
  end
endmodule // sasf_link_model

// file: sasf_status_tb.sv
// self-checking bench of the serial/audio status block
`timescale 1ns/1ps
module sasf_status_tb;
  import sasf_pkg::*;
  // design inputs, defined from time zero
  logic clk_in='0, reset_n_in='0, clk_en_in='1, data_wr_in='0;
  logic data_rd_in='0, status_rd_in='0, status_wr_in='0, ctrl1_wr_in='0;
  logic status_crc_bit_in='0, port_enable_in='0, master_select_in='0;
  logic crc_enable_in='0, sw_select_mgmt_in='0, crc_check_in='0;
  logic internal_select_level_in='0, tx_space_irq_en_in='0, ws_in='0;
  logic rx_avail_irq_en_in='0, error_irq_en_in='0, rx_threshold_sel_in='0;
  logic sync_frame_format_in='0, audio_mode_select_in='0, sck_in='0;
  logic audio_transmit_in='0, pcm_frame_sync_select_in='0, rx_push_in='0;
  logic slot_length_in='0, master_clock_out_en_in='0, item_gap_in='0;
  logic engine_active_in='0, frame_active_in='0, run='0, pulse='0;
  logic [15:0] data_wdata_in='0, rx_check_value_in='0, crc_calc_value_in='0;
  logic [5:0] tx_fifo_level_in='0, rx_fifo_level_in='0;
  sasf_std_t audio_standard_select_in = SASF_STD_DELAYED;
  sasf_len_t sample_length_in = SASF_LEN_16;
  logic link_clk_in, slave_select_pin_in, sd_in;
  // design outputs
  logic [15:0] data_rdata_out;
  logic sck_out, sck_oe_out, audio_master_clock_out, ws_out, ws_oe_out;
  logic audio_master_clock_oe_out, sd_out, sd_oe_out, port_enable_out;
  logic master_select_out, tx_space_flag_out, rx_avail_flag_out;
  logic busy_flag_out, mode_fault_flag_out, overrun_flag_out, irq_out;
  logic crc_error_flag_out, frame_error_flag_out, frame_wait_out;
  logic rx_store_en_out;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] rxt [4] = '{8'h81, 8'h82, 8'h01, 8'h00};
  sasf_status #(.FIFO_BYTES(32)) sasf_status_i (.*);
  sasf_link_model sasf_link_model_i (.run_in(run), .pulse_in(pulse),
    .link_clk_out(link_clk_in), .select_n_out(slave_select_pin_in),
    .sd_out(sd_in));
  always #2.5 clk_in = !clk_in;
  // inputs move on the falling edge, away from sampling
  task automatic cyc(int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic chk(string nm, logic e, logic g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // control-one write; two quiet cycles let flags settle
  task automatic ctrl(logic en, logic ms);
    {port_enable_in, master_select_in, ctrl1_wr_in} = {en, ms, 1'h1};
    cyc(1);
    ctrl1_wr_in = '0;
    cyc(2);
  endtask
  task automatic stat_rd;
    status_rd_in = '1;
    cyc(1);
    status_rd_in = '0;
    cyc(2);
  endtask
  task automatic crc_chk(logic [15:0] c);
    {crc_calc_value_in, rx_check_value_in, crc_check_in} = {c, 16'h1234, 1'h1};
    cyc(1);
    crc_check_in = '0;
    cyc(2);
  endtask
  initial
  begin
    cyc(8);
    reset_n_in = '1;
    cyc(2);
    {tx_space_irq_en_in, tx_fifo_level_in} = {1'h1, 6'h10};
    cyc(3);
    chk("tx_space", '1, tx_space_flag_out);
    chk("irq", '1, irq_out);
    tx_fifo_level_in = 6'h11;
    cyc(3);
    chk("tx_space", '0, tx_space_flag_out);
    chk("irq", '0, irq_out);
    rx_avail_irq_en_in = '1;
    // byte and half-word thresholds, just below and at each
    foreach (rxt[k])
    begin
      {rx_threshold_sel_in, rx_fifo_level_in} = {rxt[k][7], rxt[k][5:0]};
      cyc(3);
      chk("rx_avail", rxt[k][5:0] >= (rxt[k][7] ? 6'h02 : 6'h01),
        rx_avail_flag_out);
      chk("irq", rxt[k][5:0] >= (rxt[k][7] ? 6'h02 : 6'h01), irq_out);
    end
    {error_irq_en_in, crc_enable_in} = 2'h3;
    crc_chk(16'h1234);
    chk("crc_err", '0, crc_error_flag_out);
    crc_chk(16'h1235);
    chk("crc_err", '1, crc_error_flag_out);
    chk("irq", '1, irq_out);
    status_wr_in = '1;
    cyc(1);
    status_wr_in = '0;
    cyc(2);
    chk("crc_err", '0, crc_error_flag_out);
    // push into a full store, then data read and status read
    {rx_push_in, rx_fifo_level_in} = {1'h1, 6'h20};
    cyc(1);
    {rx_push_in, rx_fifo_level_in} = '0;
    cyc(2);
    chk("overrun", '1, overrun_flag_out);
    chk("store_en", '0, rx_store_en_out);
    data_rd_in = '1;
    cyc(1);
    data_rd_in = '0;
    stat_rd();
    chk("overrun", '0, overrun_flag_out);
    chk("store_en", '1, rx_store_en_out);
    // mode fault while master; stays until status access then write
    {sw_select_mgmt_in, internal_select_level_in} = 2'h3;
    ctrl('1, '1);
    internal_select_level_in = '0;
    cyc(3);
    chk("fault", '1, mode_fault_flag_out);
    chk("enable", '0, port_enable_out);
    chk("master", '0, master_select_out);
    internal_select_level_in = '1;
    ctrl('1, '1);
    chk("fault", '1, mode_fault_flag_out);
    chk("master", '0, master_select_out);
    stat_rd();
    ctrl('0, '0);
    chk("fault", '0, mode_fault_flag_out);
    ctrl('1, '0);
    chk("enable", '1, port_enable_out);
    engine_active_in = '1;
    cyc(3);
    chk("busy", '1, busy_flag_out);
    item_gap_in = '1;
    cyc(3);
    chk("busy", '0, busy_flag_out);
    item_gap_in = '0;
    // slave frame format: select pulse inside a frame
    {sw_select_mgmt_in, sync_frame_format_in, frame_active_in} = 3'h3;
    {run, pulse} = 2'h3;
    cyc(8);
    pulse = '0;
    repeat (50) if (frame_error_flag_out !== 1'h1) cyc(1);
    chk("frame_err", '1, frame_error_flag_out);
    chk("frame_wait", '1, frame_wait_out);
    chk("enable", '1, port_enable_out);
    stat_rd();
    chk("frame_err", '0, frame_error_flag_out);
    ctrl('0, '0);
    chk("busy", '0, busy_flag_out);
    // audio master transmit, one word through the hand-off
    {audio_mode_select_in, audio_transmit_in, master_clock_out_en_in} = 3'h7;
    ctrl('1, '1);
    chk("sck_oe", '1, sck_oe_out);
    chk("mclk_oe", '1, audio_master_clock_oe_out);
    chk("tx_space", '1, tx_space_flag_out);
    {data_wr_in, data_wdata_in} = {1'h1, 16'ha5c3};
    cyc(1);
    data_wr_in = '0;
    cyc(1);
    chk("tx_space", '0, tx_space_flag_out);
    chk("busy", '1, busy_flag_out);
    repeat (100) if (tx_space_flag_out !== 1'h1) cyc(1);
    chk("tx_space", '1, tx_space_flag_out);
    chk("ws_oe", '1, ws_oe_out);
    end_of_test();
  end
endmodule // sasf_status_tb
